// ==== include/tbd_pkg.sv ====
package tbd_pkg;
  // ----------------------------------------
  // Limits and widths
  // ----------------------------------------
  localparam int unsigned TBD_ID_W = 8;
  localparam int unsigned TBD_NAK_CNT_W = 8;
  localparam logic [7:0] TBD_NAK_LIMIT_LONG = 8'h80;
  localparam logic [7:0] TBD_NAK_LIMIT_SHORT = 8'h04;
  localparam logic [7:0] TBD_NEXT_ID_RST = 8'h00;
  // Host mapping wait, kept for reference by software models
  localparam int unsigned TBD_MAP_WAIT_MS = 840;
  // Event detector states
  typedef enum logic [1:0] {
    TBD_TENT_IDLE,
    TBD_TENT_ARMED,
    TBD_TENT_DONE
  } tbd_tent_t;
endpackage

// ==== include/tbd_evt_if.sv ====
`timescale 1ns/1ps
interface tbd_evt_if;
  logic [4:0] evt_set;
  logic [4:0] evt_clr;
  logic [4:0] flags;
  logic irq;
  modport core (output evt_set, output evt_clr, input flags, input irq);
  modport unit (input evt_set, input evt_clr, output flags, output irq);
endinterface

// ==== hw/tbd_irq_unit.sv ====
`timescale 1ns/1ps
module tbd_irq_unit (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Event carrier
  tbd_evt_if.unit ev
);
  logic [4:0] flag_q;
  logic [4:0] flag_d;

  // ----------------------------------------
  // Sticky flags, set wins over clear
  // ----------------------------------------
  assign flag_d = (flag_q & ~ev.evt_clr) | ev.evt_set;
  assign ev.flags = flag_q;
  // Level interrupt held while any flag stands
  assign ev.irq = |flag_q;

  // Flag register
  always_ff @(posedge clk) begin
    if (rst) begin
      flag_q <= 5'h00;
    end else begin
      flag_q <= flag_d;
    end
  end
endmodule

// ==== hw/tbd_diag.sv ====
`timescale 1ns/1ps
// Summary of operation
// - Unanswered enquiry count reaching limit sets excess flag and interrupt; default 128.
// - Short-limit input drops the enquiry limit to four retries.
// - Enquiries keep going after the excess event until host aborts or retries.
// - Clear-flags command clears the excess flag; the interrupt drops only once no receive or transmit flag stands.
// - On network, own transmit after token receipt sets duplicate-ID flag.
// - Reading diagnostic status clears the duplicate-ID flag.
// - Tentative ID seen active during the next rotation sets tentative flag.
// - Successor node is never reported by the tentative detector.
// - Every successor register update raises the successor-changed event.
// - Successor register updates on mini and full reconfiguration.
// - Successor register is readable by the host.
// - One shared interrupt from receive, transmit, excess, reconfig, successor change.
module tbd_diag (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Setup and host commands
  input wire logic short_nak_limit,
  input wire logic cmd_clear_flags,
  input wire logic cmd_disable_tx,
  input wire logic cmd_clear_rx,
  input wire logic cmd_clear_tx,
  input wire logic diag_status_rd,
  input wire logic tentative_id_wr,
  input wire logic [tbd_pkg::TBD_ID_W-1:0] tentative_id_data,
  // Protocol engine events, same clock
  input wire logic tx_pending,
  input wire logic free_buffer_enquiry,
  input wire logic enquiry_answered,
  input wire logic on_network,
  input wire logic token_received,
  input wire logic own_tx_seen,
  input wire logic rotation_mark,
  input wire logic rx_activity,
  input wire logic [tbd_pkg::TBD_ID_W-1:0] rx_source_id,
  input wire logic recon_mini,
  input wire logic recon_full,
  input wire logic [tbd_pkg::TBD_ID_W-1:0] new_successor_id,
  input wire logic packet_received,
  input wire logic tx_done,
  // Status outputs
  output logic excess_nak_flag,
  output logic duplicate_id_flag,
  output logic tentative_id_flag,
  output logic successor_changed,
  output logic receiver_inhibited,
  output logic transmitter_available,
  output logic recon_flag,
  output logic [tbd_pkg::TBD_ID_W-1:0] next_id,
  output logic irq
);
  import tbd_pkg::*;

  tbd_evt_if ev ();

  logic [TBD_NAK_CNT_W-1:0] nak_cnt_q;
  logic [TBD_NAK_CNT_W-1:0] nak_cnt_d;
  logic nak_fired_q;
  logic dup_q;
  logic dup_armed_q;
  logic tent_flag_q;
  tbd_tent_t tent_st_q;
  tbd_tent_t tent_st_d;
  logic [TBD_ID_W-1:0] tent_id_q;
  logic [TBD_ID_W-1:0] next_id_q;
  logic recon_any;
  logic succ_upd;

  // ----------------------------------------
  // Excess negative acknowledge counting
  // ----------------------------------------
  // Compare against the limit minus one so the event lands on the limit-th miss
  wire [TBD_NAK_CNT_W-1:0] nak_limit =
    short_nak_limit ? TBD_NAK_LIMIT_SHORT : TBD_NAK_LIMIT_LONG;
  wire nak_miss = free_buffer_enquiry && !enquiry_answered;
  wire nak_hit = nak_miss && !nak_fired_q &&
    (nak_cnt_q == nak_limit - 8'h01);
  // Count never stalls enquiries; the engine keeps asking until host acts
  wire nak_reset = !tx_pending || cmd_disable_tx || enquiry_answered;
  assign nak_cnt_d = nak_reset ? '0 :
    (nak_miss && !nak_fired_q) ? nak_cnt_q + 8'h01 : nak_cnt_q;

  // Counter and one-shot guard per transmission
  always_ff @(posedge clk) begin
    if (rst) begin
      nak_cnt_q <= '0;
      nak_fired_q <= 1'b0;
    end else begin
      nak_cnt_q <= nak_cnt_d;
      nak_fired_q <= nak_reset ? 1'b0 : (nak_fired_q | nak_hit);
    end
  end

  // ----------------------------------------
  // Duplicate-ID detection
  // ----------------------------------------
  wire dup_set = on_network && dup_armed_q && own_tx_seen;

  // Arm on token, flag on own activity; a read clears but a new set wins
  always_ff @(posedge clk) begin
    if (rst) begin
      dup_armed_q <= 1'b0;
      dup_q <= 1'b0;
    end else begin
      dup_armed_q <= token_received | (dup_armed_q & ~own_tx_seen);
      dup_q <= dup_set | (dup_q & ~diag_status_rd);
    end
  end

  // ----------------------------------------
  // Tentative-ID detection
  // ----------------------------------------
  // Successor cannot be heard while we send it the token, so never match it
  wire tent_match = rx_activity && (rx_source_id == tent_id_q) &&
    (tent_id_q != next_id_q);

  always_comb begin
    tent_st_d = tent_st_q;
    unique case (tent_st_q)
      TBD_TENT_IDLE: begin
        if (rotation_mark) begin
          tent_st_d = TBD_TENT_ARMED;
        end
      end
      TBD_TENT_ARMED: begin
        if (rotation_mark) begin
          tent_st_d = TBD_TENT_DONE;
        end
      end
      TBD_TENT_DONE: begin
        tent_st_d = TBD_TENT_DONE;
      end
    endcase
    if (tentative_id_wr) begin
      tent_st_d = TBD_TENT_IDLE;
    end
  end

  // Window opens at next rotation start, shuts one rotation later
  wire tent_window = (tent_st_q == TBD_TENT_ARMED) ||
    (tent_st_q == TBD_TENT_IDLE && rotation_mark);

  always_ff @(posedge clk) begin
    if (rst) begin
      tent_st_q <= TBD_TENT_IDLE;
      tent_id_q <= '0;
      tent_flag_q <= 1'b0;
    end else begin
      tent_st_q <= tent_st_d;
      if (tentative_id_wr) begin
        tent_id_q <= tentative_id_data;
        tent_flag_q <= 1'b0;
      end else if (tent_window && tent_match) begin
        tent_flag_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Successor register
  // ----------------------------------------
  assign recon_any = recon_mini | recon_full;
  assign succ_upd = recon_any;

  always_ff @(posedge clk) begin
    if (rst) begin
      next_id_q <= TBD_NEXT_ID_RST;
    end else if (succ_upd) begin
      next_id_q <= new_successor_id;
    end
  end

  // ----------------------------------------
  // Shared event flags
  // ----------------------------------------
  // Bit order: receive, transmit, excess, reconfig, successor change
  assign ev.evt_set = {succ_upd, recon_any, nak_hit, tx_done, packet_received};
  assign ev.evt_clr = {cmd_clear_flags, cmd_clear_flags, cmd_clear_flags,
    cmd_clear_tx, cmd_clear_rx};

  tbd_irq_unit u_irq (
    .clk (clk),
    .rst (rst),
    .ev (ev.unit)
  );

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign receiver_inhibited = ev.flags[0];
  assign transmitter_available = ev.flags[1];
  assign excess_nak_flag = ev.flags[2];
  assign recon_flag = ev.flags[3];
  assign successor_changed = ev.flags[4];
  assign duplicate_id_flag = dup_q;
  assign tentative_id_flag = tent_flag_q;
  assign next_id = next_id_q;
  assign irq = ev.irq;
endmodule

// ==== testbench/tbd_diag_props.sv ====
`timescale 1ns/1ps
module tbd_diag_props (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Causes
  input wire logic cmd_clear_flags,
  input wire logic diag_status_rd,
  input wire logic free_buffer_enquiry,
  input wire logic enquiry_answered,
  input wire logic on_network,
  input wire logic token_received,
  input wire logic own_tx_seen,
  input wire logic recon_mini,
  input wire logic recon_full,
  input wire logic [tbd_pkg::TBD_ID_W-1:0] new_successor_id,
  // Effects
  input wire logic excess_nak_flag,
  input wire logic duplicate_id_flag,
  input wire logic successor_changed,
  input wire logic [tbd_pkg::TBD_ID_W-1:0] next_id,
  input wire logic irq
);
  import tbd_pkg::*;
  // One domain, so clock and reset are given once
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_exc_rise;
    $rose(excess_nak_flag) |-> $past(free_buffer_enquiry) && !$past(enquiry_answered);
  endproperty
  a_exc_rise: assert property (p_exc_rise) else $error("excess flag without miss");
  property p_exc_clr;
    cmd_clear_flags && !free_buffer_enquiry |=> !excess_nak_flag;
  endproperty
  a_exc_clr: assert property (p_exc_clr) else $error("excess flag not cleared");
  property p_exc_hold;
    $fell(excess_nak_flag) |-> $past(cmd_clear_flags);
  endproperty
  a_exc_hold: assert property (p_exc_hold) else $error("excess flag fell alone");
  property p_irq_src;
    excess_nak_flag || successor_changed |-> irq;
  endproperty
  a_irq_src: assert property (p_irq_src) else $error("irq missing");
  property p_dup_set;
    (on_network && token_received) ##1 (on_network && own_tx_seen) |=> duplicate_id_flag;
  endproperty
  a_dup_set: assert property (p_dup_set) else $error("duplicate flag not set");
  property p_dup_rd;
    diag_status_rd && !own_tx_seen |=> !duplicate_id_flag;
  endproperty
  a_dup_rd: assert property (p_dup_rd) else $error("duplicate flag not cleared");
  property p_succ;
    recon_mini || recon_full |=> successor_changed && next_id == $past(new_successor_id);
  endproperty
  a_succ: assert property (p_succ) else $error("successor not taken");
  property p_next_hold;
    !(recon_mini || recon_full) |=> $stable(next_id);
  endproperty
  a_next_hold: assert property (p_next_hold) else $error("successor moved");
endmodule
bind tbd_diag tbd_diag_props i_tbd_diag_props (.*);

// ==== testbench/tbd_host_model.sv ====
`timescale 1ns/1ps
module tbd_host_model (
  // Clock and mode
  input wire logic clk,
  input wire logic en,
  input wire logic slow,
  // Device status and commands
  input wire logic excess_nak_flag,
  output logic cmd_disable_tx,
  output logic cmd_clear_flags
);
  // Service: abort first, then release; slow mode mimics a busy handler
  initial begin
    cmd_disable_tx = 1'b0;
    cmd_clear_flags = 1'b0;
    forever begin
      @(posedge clk);
      if (en && excess_nak_flag) begin
        repeat (slow ? 12 : 1) @(posedge clk);
        #1 cmd_disable_tx = 1'b1;
        @(posedge clk);
        #1 cmd_disable_tx = 1'b0;
        cmd_clear_flags = 1'b1;
        @(posedge clk);
        #1 cmd_clear_flags = 1'b0;
      end
    end
  end
endmodule

// ==== testbench/test_tbd_diag.sv ====
`timescale 1ns/1ps
`define CHK(nm, e, a) begin compares++; if ((a) !== (e)) begin n_fail++; \
  $display("BAD %s exp %h got %h", nm, e, a); end end
module test_tbd_diag;
  import tbd_pkg::*;
  logic clk = 0, rst = 1, short_nak_limit = 0, clr_t = 0, cmd_clear_rx = 0, cmd_clear_tx = 0;
  logic diag_status_rd = 0, tentative_id_wr = 0, tx_pending = 0, free_buffer_enquiry = 0;
  logic enquiry_answered = 0, on_network = 0, token_received = 0, own_tx_seen = 0, en = 0;
  logic rotation_mark = 0, rx_activity = 0, recon_mini = 0, recon_full = 0, slow = 0;
  logic packet_received = 0, tx_done = 0, clr_m, cmd_disable_tx, excess_nak_flag, irq;
  logic [TBD_ID_W-1:0] tentative_id_data = 8'h00, rx_source_id = 8'h00;
  logic [TBD_ID_W-1:0] new_successor_id = 8'h00, next_id;
  logic duplicate_id_flag, tentative_id_flag, successor_changed, recon_flag;
  logic receiver_inhibited, transmitter_available;
  wire cmd_clear_flags = clr_t | clr_m;
  int n_fail = 0, compares = 0, cyc = 0;
  tbd_diag i_tbd_diag (.*);
  tbd_host_model i_tbd_host_model (.clk(clk), .en(en), .slow(slow),
    .excess_nak_flag(excess_nak_flag), .cmd_disable_tx(cmd_disable_tx), .cmd_clear_flags(clr_m));
  // 250 MHz clock; hang guard well above the expected run
  initial forever #2 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin n_fail++; final_report; end
  end
  task tick; @(posedge clk); #1; endtask
  task final_report;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Misses back to back; the host model aborts and releases
  task nak(input logic s, input int n);
    short_nak_limit = s; slow = !s; tx_pending = 1; free_buffer_enquiry = 1;
    repeat (n - 1) tick;
    `CHK("exc_early", 1'b0, excess_nak_flag)
    tick;
    `CHK("exc", 1'b1, excess_nak_flag)
    `CHK("irq", 1'b1, irq)
    free_buffer_enquiry = 0;
    repeat (20) tick;
    `CHK("exc_clr", 1'b0, excess_nak_flag)
    `CHK("irq_clr", 1'b0, irq)
    tx_pending = 0;
  endtask
  task succ;
    new_successor_id = 8'h07; recon_mini = 1; tick; recon_mini = 0;
    `CHK("next", 8'h07, next_id)
    `CHK("succ", 1'b1, successor_changed)
    `CHK("recon", 1'b1, recon_flag)
    clr_t = 1; tick; clr_t = 0;
    `CHK("succ_clr", 1'b0, successor_changed)
    new_successor_id = 8'h09; recon_full = 1; tick; recon_full = 0; clr_t = 1; tick; clr_t = 0;
    `CHK("next2", 8'h09, next_id)
  endtask
  task rxtx;
    packet_received = 1; tick; packet_received = 0;
    `CHK("ri", 1'b1, receiver_inhibited)
    cmd_clear_rx = 1; tx_done = 1; tick; cmd_clear_rx = 0; tx_done = 0;
    `CHK("ta", 1'b1, transmitter_available)
    cmd_clear_tx = 1; tick; cmd_clear_tx = 0;
    `CHK("irq_idle", 1'b0, irq)
  endtask
  // Write an ID, open a rotation, let that node talk
  task tent(input logic [7:0] id, input logic e);
    tentative_id_data = id; tentative_id_wr = 1; tick; tentative_id_wr = 0;
    rotation_mark = 1; tick; rotation_mark = 0;
    rx_source_id = id; rx_activity = 1; tick; rx_activity = 0; tick;
    `CHK("tent", e, tentative_id_flag)
  endtask
  task dup(input logic net, input logic e);
    on_network = net; token_received = 1; tick; token_received = 0;
    own_tx_seen = 1; tick; own_tx_seen = 0;
    `CHK("dup", e, duplicate_id_flag)
  endtask
  initial begin
    repeat (8) tick;
    rst = 0; en = 1;
    nak(1, 4); nak(0, 128); succ; rxtx;
    tent(8'h09, 1'b0); tent(8'h05, 1'b1);
    dup(0, 1'b0); dup(1, 1'b1);
    diag_status_rd = 1; tick; diag_status_rd = 0;
    `CHK("dup_rd", 1'b0, duplicate_id_flag)
    final_report;
  end
endmodule
